// ===== lfs_regs.svh
// Register map, field positions, reset values and timing counts
`ifndef LFS_REGS_SVH
`define LFS_REGS_SVH

`define LFS_ADDR_W 12
`define LFS_FULL_STATUS_ADDR 12'h30C
`define LFS_EMPTY_STATUS_ADDR 12'h30D
`define LFS_MASK_CTRL_ADDR 12'h311
`define LFS_PULSE_CTRL_ADDR 12'h312

`define LFS_STATUS_RST 8'h00
`define LFS_MASK_CTRL_RST 8'h00
`define LFS_PULSE_CTRL_RST 8'h00
`define LFS_MASK_CTRL_WMASK 8'h07

`define LFS_FRAME_MASK_BIT 0
`define LFS_MFRAME_MASK_BIT 2
`define LFS_ERR_LEN_HI 7
`define LFS_ERR_LEN_LO 4
`define LFS_REQ_LEN_HI 3
`define LFS_REQ_LEN_LO 0

`define LFS_PCLK_OCTETS 4
`define LFS_REQ_BASE_FRAMES 5
`define LFS_REQ_BASE_OCTETS 9
`define LFS_CNT_W 6

`endif

// ===== lfs_pkg.sv
// Types shared by the lane status and sync request block
package lfs_pkg;

  typedef struct packed {
    logic [7:0] full;
    logic [7:0] empty;
  } lfs_lane_status_t;

  typedef struct packed {
    logic frame_loss;
    logic multiframe_sync_loss;
  } lfs_decoder_loss_t;

  typedef enum logic [1:0] {
    LFS_IDLE,
    LFS_REQUEST,
    LFS_ERROR_RPT
  } lfs_pulse_state_t;

endpackage : lfs_pkg

// ===== lfs_sync_report.sv
// Lane buffer status registers and sync request pulse generator
`timescale 1ns/1ps
`include "lfs_regs.svh"

module lfs_sync_report
  import lfs_pkg::*;
#(
  parameter int FRAME_OCTETS = 1
) (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire logic [`LFS_ADDR_W-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic [7:0] LANE_BUFFER_FULL_I,
  input wire logic [7:0] LANE_BUFFER_EMPTY_I,
  input wire logic LANE_DECODER_ZERO_FRAME_LOSS_I,
  input wire logic LANE_DECODER_ZERO_MULTIFRAME_SYNC_LOSS_I,
  input wire logic SYNC_ERROR_EVENT_I,
  output logic SYNC_REQUEST_OUTPUT_N_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one system clock is one parallel clock of four octets

  // Base request time rounded up to whole parallel clocks
  localparam int REQ_BASE_OCTETS_TOTAL =
    `LFS_REQ_BASE_FRAMES * FRAME_OCTETS + `LFS_REQ_BASE_OCTETS;
  localparam int REQ_BASE_CYCLES =
    (REQ_BASE_OCTETS_TOTAL + `LFS_PCLK_OCTETS - 1) / `LFS_PCLK_OCTETS;
  localparam logic [`LFS_CNT_W-1:0] REQ_BASE = REQ_BASE_CYCLES[`LFS_CNT_W-1:0];
  localparam logic [`LFS_CNT_W-1:0] ONE = 6'h01;

  // Request low time in cycles for a 4-bit code
  function automatic logic [`LFS_CNT_W-1:0] req_len(input logic [3:0] code);
    req_len = REQ_BASE + {2'h0, code};
  endfunction : req_len

  // Half a cycle cannot be made on this clock, so it rounds up to one
  function automatic logic [`LFS_CNT_W-1:0] err_len(input logic [3:0] code);
    err_len = ONE + {2'h0, code};
  endfunction : err_len

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  lfs_lane_status_t status_reg;
  lfs_decoder_loss_t loss;
  logic [7:0] mask_ctrl_reg;
  logic [7:0] pulse_ctrl_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  assign loss.frame_loss = LANE_DECODER_ZERO_FRAME_LOSS_I;
  assign loss.multiframe_sync_loss = LANE_DECODER_ZERO_MULTIFRAME_SYNC_LOSS_I;

  // Flags come from buffers on this clock, so no synchroniser
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      status_reg.full <= `LFS_STATUS_RST;
      status_reg.empty <= `LFS_STATUS_RST;
    end else if (CE_I) begin
      status_reg.full <= LANE_BUFFER_FULL_I;
      status_reg.empty <= LANE_BUFFER_EMPTY_I;
    end
  end

  // Bits 7:3 are reserved and read zero; bit 1 is kept as written
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      mask_ctrl_reg <= `LFS_MASK_CTRL_RST;
    end else if (CE_I && REG_WR_I && REG_ADDR_I == `LFS_MASK_CTRL_ADDR) begin
      mask_ctrl_reg <= REG_WDATA_I & `LFS_MASK_CTRL_WMASK;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      pulse_ctrl_reg <= `LFS_PULSE_CTRL_RST;
    end else if (CE_I && REG_WR_I && REG_ADDR_I == `LFS_PULSE_CTRL_ADDR) begin
      pulse_ctrl_reg <= REG_WDATA_I;
    end
  end

  always_comb begin
    case (REG_ADDR_I)
      `LFS_FULL_STATUS_ADDR: rdata_next = status_reg.full;
      `LFS_EMPTY_STATUS_ADDR: rdata_next = status_reg.empty;
      `LFS_MASK_CTRL_ADDR: rdata_next = mask_ctrl_reg;
      `LFS_PULSE_CTRL_ADDR: rdata_next = pulse_ctrl_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      rdata_reg <= 8'h00;
    end else if (CE_I && REG_RD_I) begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA_O = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Sync request generation

  logic frame_mask;
  logic mframe_mask;
  logic loss_req;
  logic [3:0] err_code;
  logic [3:0] req_code;
  lfs_pulse_state_t state_reg;
  lfs_pulse_state_t state_next;
  logic [`LFS_CNT_W-1:0] cnt_reg;
  logic [`LFS_CNT_W-1:0] cnt_next;
  logic out_n_reg;

  assign frame_mask = mask_ctrl_reg[`LFS_FRAME_MASK_BIT];
  assign mframe_mask = mask_ctrl_reg[`LFS_MFRAME_MASK_BIT];
  assign err_code = pulse_ctrl_reg[`LFS_ERR_LEN_HI:`LFS_ERR_LEN_LO];
  assign req_code = pulse_ctrl_reg[`LFS_REQ_LEN_HI:`LFS_REQ_LEN_LO];

  // Masked losses from decoder zero only; other decoders are not watched
  assign loss_req = (loss.multiframe_sync_loss && mframe_mask)
                 || (loss.frame_loss && frame_mask);

  // A loss outranks an error report, since resync supersedes the report
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      LFS_IDLE: begin
        if (loss_req) begin
          state_next = LFS_REQUEST;
          cnt_next = req_len(req_code) - ONE;
        end else if (SYNC_ERROR_EVENT_I) begin
          state_next = LFS_ERROR_RPT;
          cnt_next = err_len(err_code) - ONE;
        end
      end
      LFS_REQUEST: begin
        if (loss_req) begin
          cnt_next = req_len(req_code) - ONE;
        end else if (cnt_reg == '0) begin
          state_next = LFS_IDLE;
        end else begin
          cnt_next = cnt_reg - ONE;
        end
      end
      LFS_ERROR_RPT: begin
        if (loss_req) begin
          state_next = LFS_REQUEST;
          cnt_next = req_len(req_code) - ONE;
        end else if (cnt_reg == '0) begin
          state_next = LFS_IDLE;
        end else begin
          cnt_next = cnt_reg - ONE;
        end
      end
      default: begin
        state_next = LFS_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= LFS_IDLE;
      cnt_reg <= '0;
    end else if (CE_I) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Output low exactly while a pulse is in progress
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      out_n_reg <= 1'b1;
    end else if (CE_I) begin
      out_n_reg <= (state_next == LFS_IDLE);
    end
  end

  assign SYNC_REQUEST_OUTPUT_N_O = out_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [`LFS_CNT_W-1:0] low_cnt_reg;
  logic [`LFS_CNT_W-1:0] exp_len_reg;
  logic was_err_reg;

  // Counts low cycles of the current pulse and records the expected length of an error report
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      low_cnt_reg <= '0;
      exp_len_reg <= '0;
      was_err_reg <= 1'b0;
    end else if (CE_I) begin
      if (state_next == LFS_IDLE) begin
        low_cnt_reg <= '0;
      end else begin
        low_cnt_reg <= low_cnt_reg + ONE;
      end
      if (state_reg == LFS_IDLE && state_next == LFS_ERROR_RPT) begin
        exp_len_reg <= err_len(err_code);
        was_err_reg <= 1'b1;
      end else if (state_next == LFS_REQUEST) begin
        was_err_reg <= 1'b0;
      end
    end
  end

  full_reset_a: assert property (@(posedge SYS_CLK_I)
    SYS_RST_I |=> status_reg.full == 8'h00)
    else $error("full flags not cleared by reset");

  empty_track_a: assert property (@(posedge SYS_CLK_I)
    disable iff (SYS_RST_I)
    CE_I ##1 CE_I |-> REG_RD_I && REG_ADDR_I == `LFS_EMPTY_STATUS_ADDR
    |=> REG_RDATA_O == $past(LANE_BUFFER_EMPTY_I, 2))
    else $error("empty status read does not show lane flags");

  mframe_on_a: assert property (@(posedge SYS_CLK_I)
    disable iff (SYS_RST_I)
    CE_I && mframe_mask && LANE_DECODER_ZERO_MULTIFRAME_SYNC_LOSS_I
    |=> !SYNC_REQUEST_OUTPUT_N_O)
    else $error("multiframe loss did not pull sync output low");

  mframe_off_a: assert property (@(posedge SYS_CLK_I)
    disable iff (SYS_RST_I)
    CE_I && state_reg == LFS_IDLE && !SYNC_ERROR_EVENT_I && !mframe_mask
    && !(frame_mask && LANE_DECODER_ZERO_FRAME_LOSS_I)
    |=> SYNC_REQUEST_OUTPUT_N_O)
    else $error("unmasked multiframe loss drove sync output");

  frame_on_a: assert property (@(posedge SYS_CLK_I)
    disable iff (SYS_RST_I)
    CE_I && frame_mask && LANE_DECODER_ZERO_FRAME_LOSS_I
    |=> !SYNC_REQUEST_OUTPUT_N_O [*1] ##0 state_reg == LFS_REQUEST)
    else $error("frame loss did not start a sync request");

  frame_hold_a: assert property (@(posedge SYS_CLK_I)
    disable iff (SYS_RST_I)
    (CE_I && frame_mask && LANE_DECODER_ZERO_FRAME_LOSS_I) [*3]
    |=> !SYNC_REQUEST_OUTPUT_N_O && !$past(SYNC_REQUEST_OUTPUT_N_O))
    else $error("sync output released during frame loss");

  frame_off_a: assert property (@(posedge SYS_CLK_I)
    disable iff (SYS_RST_I)
    CE_I && state_reg == LFS_IDLE && !SYNC_ERROR_EVENT_I && !frame_mask
    && !(mframe_mask && LANE_DECODER_ZERO_MULTIFRAME_SYNC_LOSS_I)
    |=> SYNC_REQUEST_OUTPUT_N_O)
    else $error("unmasked frame loss drove sync output");

  err_len_a: assert property (@(posedge SYS_CLK_I)
    disable iff (SYS_RST_I)
    CE_I && state_reg == LFS_ERROR_RPT && state_next == LFS_IDLE
    && was_err_reg
    |-> low_cnt_reg == exp_len_reg)
    else $error("error report low time wrong");

  req_len_a: assert property (@(posedge SYS_CLK_I)
    disable iff (SYS_RST_I)
    CE_I && state_reg == LFS_REQUEST && state_next == LFS_IDLE
    |-> low_cnt_reg >= req_len(req_code))
    else $error("sync request low time too short");

endmodule : lfs_sync_report

// ===== lfs_tx_model.sv
// Link transmitter model that times the low pulses on the sync line
`timescale 1ns/1ps
module lfs_tx_model (
  input wire logic clk_i,
  input wire logic sync_n_i,
  output int len_o,
  output int cnt_o
);
  int run_reg = 0;
  int len_reg = 0;
  int cnt_reg = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Counts low cycles; a pulse is reported only once the line returns high
  always @(posedge clk_i) begin
    if (sync_n_i === 1'b0) begin
      run_reg <= run_reg + 1;
    end else if (run_reg != 0) begin
      len_reg <= run_reg;
      cnt_reg <= cnt_reg + 1;
      run_reg <= 0;
    end
  end
  assign len_o = len_reg;
  assign cnt_o = cnt_reg;
endmodule : lfs_tx_model

// ===== tb_top.sv
// Self-checking testbench for the lane status and sync request block
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic fr_loss = 1'b0;
  logic mf_loss = 1'b0;
  logic err_ev = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] full_flags = 8'h00;
  logic [7:0] empty_flags = 8'h00;
  wire logic [7:0] rdata;
  wire logic sync_n;
  int len;
  int cnt;
  int err_count = 0;
  int num_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  lfs_sync_report u_dut (
    .SYS_CLK_I(sys_clk),
    .SYS_RST_I(sys_rst),
    .CE_I(ce),
    .REG_ADDR_I(addr),
    .REG_WR_I(wr_en),
    .REG_WDATA_I(wdata),
    .REG_RD_I(rd_en),
    .REG_RDATA_O(rdata),
    .LANE_BUFFER_FULL_I(full_flags),
    .LANE_BUFFER_EMPTY_I(empty_flags),
    .LANE_DECODER_ZERO_FRAME_LOSS_I(fr_loss),
    .LANE_DECODER_ZERO_MULTIFRAME_SYNC_LOSS_I(mf_loss),
    .SYNC_ERROR_EVENT_I(err_ev),
    .SYNC_REQUEST_OUTPUT_N_O(sync_n)
  );
  lfs_tx_model u_tx (
    .clk_i(sys_clk),
    .sync_n_i(sync_n),
    .len_o(len),
    .cnt_o(cnt)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr
  // Read data is registered, so it is taken one edge after the strobe
  task automatic rd(logic [11:0] a, logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(posedge sys_clk);
    chk("read data", e, rdata);
  endtask : rd
  // Kind 0 frame loss, 1 multiframe loss, 2 error event, held hold cycles
  task automatic pulse(int kind, int n, logic [7:0] e, int hold = 1);
    int c0;
    c0 = cnt;
    @(posedge sys_clk);
    fr_loss <= (kind == 0);
    mf_loss <= (kind == 1);
    err_ev <= (kind == 2);
    repeat (hold) @(posedge sys_clk);
    fr_loss <= 1'b0;
    mf_loss <= 1'b0;
    err_ev <= 1'b0;
    // Longest pulse is 19 cycles, so 25 leaves margin for the rise
    repeat (25) @(posedge sys_clk);
    chk("pulse count", 8'(c0 + n), 8'(cnt));
    if (n == 1) chk("pulse length", e, 8'(len));
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(12'h30C, 8'h00);
    rd(12'h30D, 8'h00);
    rd(12'h311, 8'h00);
    rd(12'h312, 8'h00);
  endtask : t_reset
  // Flag patterns are not mirror images, so a reversed lane order shows
  task automatic t_status;
    full_flags <= 8'h1D;
    empty_flags <= 8'h62;
    wr(12'h30C, 8'hFF);
    wr(12'h30D, 8'h00);
    rd(12'h30C, 8'h1D);
    rd(12'h30D, 8'h62);
    rd(12'h310, 8'h00);
    wr(12'h311, 8'hFF);
    rd(12'h311, 8'h07);
  endtask : t_status
  task automatic t_frame;
    wr(12'h311, 8'h00);
    pulse(0, 0, 8'h00);
    wr(12'h311, 8'h01);
    pulse(0, 1, 8'h04);
    pulse(0, 1, 8'h06, 3);
    wr(12'h312, 8'h05);
    pulse(0, 1, 8'h09);
    pulse(1, 0, 8'h00);
  endtask : t_frame
  task automatic t_mframe;
    wr(12'h311, 8'h04);
    pulse(1, 1, 8'h09);
    pulse(0, 0, 8'h00);
    wr(12'h312, 8'h0F);
    pulse(1, 1, 8'h13);
  endtask : t_mframe
  // Loss during an error report restarts as a request; events in one drop
  task automatic t_overlap;
    int c0;
    wr(12'h311, 8'h01);
    wr(12'h312, 8'h30);
    c0 = cnt;
    @(posedge sys_clk);
    err_ev <= 1'b1;
    @(posedge sys_clk);
    err_ev <= 1'b0;
    fr_loss <= 1'b1;
    @(posedge sys_clk);
    fr_loss <= 1'b0;
    repeat (25) @(posedge sys_clk);
    chk("pulse count", 8'(c0 + 1), 8'(cnt));
    chk("pulse length", 8'h05, 8'(len));
    c0 = cnt;
    @(posedge sys_clk);
    fr_loss <= 1'b1;
    @(posedge sys_clk);
    fr_loss <= 1'b0;
    err_ev <= 1'b1;
    @(posedge sys_clk);
    err_ev <= 1'b0;
    repeat (25) @(posedge sys_clk);
    chk("pulse count", 8'(c0 + 1), 8'(cnt));
    chk("pulse length", 8'h04, 8'(len));
  endtask : t_overlap
  // A low enable freezes the pulse counter, so the pulse stretches
  task automatic t_freeze;
    int c0;
    wr(12'h312, 8'h00);
    c0 = cnt;
    @(posedge sys_clk);
    fr_loss <= 1'b1;
    @(posedge sys_clk);
    fr_loss <= 1'b0;
    ce <= 1'b0;
    repeat (3) @(posedge sys_clk);
    ce <= 1'b1;
    repeat (25) @(posedge sys_clk);
    chk("pulse count", 8'(c0 + 1), 8'(cnt));
    chk("pulse length", 8'h07, 8'(len));
  endtask : t_freeze
  // Reset in mid pulse releases the line at once and clears the masks
  task automatic t_rst;
    int c0;
    c0 = cnt;
    @(posedge sys_clk);
    fr_loss <= 1'b1;
    @(posedge sys_clk);
    fr_loss <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(12'h311, 8'h00);
    chk("pulse count", 8'(c0 + 1), 8'(cnt));
    chk("pulse length", 8'h01, 8'(len));
    pulse(0, 0, 8'h00);
  endtask : t_rst
  task automatic t_error;
    wr(12'h312, 8'h00);
    pulse(2, 1, 8'h01);
    wr(12'h312, 8'h30);
    pulse(2, 1, 8'h04);
    wr(12'h312, 8'hF0);
    pulse(2, 1, 8'h10);
  endtask : t_error
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_status();
    t_frame();
    t_mframe();
    t_overlap();
    t_freeze();
    t_rst();
    t_error();
    print_verdict();
  end
  // Whole run needs under 1000 cycles; the limit allows 4000
  initial begin
    #100us;
    err_count++;
    print_verdict();
  end
endmodule : tb_top
